/* File: hdl/cdc_pkg.sv */
// package: register map, field layout and reset values of the clock divider control
package cdc_pkg;
  localparam logic [31:0] CDC_DIV_SEL_ADDR = 32'hFFFFE800;
  localparam logic [31:0] CDC_OSC_STOP_ADDR = 32'hFFFFE814;
  localparam logic [15:0] CDC_DIV_SEL_RESET = 16'h36DB;
  localparam logic [7:0] CDC_OSC_STOP_RESET = 8'h00;
  localparam int CDC_CORE_LSB = 12;
  localparam int CDC_BUS_LSB = 9;
  localparam int CDC_PERIPH_LSB = 6;
  localparam int CDC_RSVD_LSB = 3;
  localparam int CDC_TIMER_LSB = 0;
  localparam int CDC_RSVD_TOP_BIT = 15;
  localparam logic [2:0] CDC_RSVD_VALUE = 3'h3;
  localparam int CDC_OSC_SELECT_BIT = 0;
  localparam int CDC_OSC_FLAG_BIT = 2;
  localparam logic [7:0] CDC_OSC_WR_MASK = 8'h01;
  localparam int CDC_PLL_MULT = 8;
  localparam int CDC_PRESCALE_W = 3;
  localparam logic [2:0] CDC_DIV_HALF = 3'h1;
  localparam logic [2:0] CDC_DIV_QUARTER = 3'h3;
  localparam logic [2:0] CDC_DIV_EIGHTH = 3'h4;
  localparam logic [1:0] CDC_SIZE_BYTE = 2'h0;
  localparam logic [1:0] CDC_SIZE_WORD = 2'h1;
  localparam logic [1:0] CDC_SIZE_LONG = 2'h2;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] size;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } cdc_req_t;

  typedef struct packed {
    logic core;
    logic bus;
    logic periph;
    logic timer;
  } cdc_clk_en_t;

  typedef enum logic [2:0] {
    CDC_ST_RUN = 3'b001,
    CDC_ST_WAIT = 3'b010,
    CDC_ST_LOAD = 3'b100
  } cdc_state_t;
endpackage

/* File: hdl/cdc_clk_gate.sv */
// one derived clock: turns the shared prescale count into an enable pulse
`timescale 1ns/1ps
module cdc_clk_gate (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // shared prescaler and selected code
  input wire logic [2:0] cnt,
  input wire logic [2:0] sel,
  // derived clock enable
  output logic en
);
  import cdc_pkg::*;
  logic nxt_en;

  // one pulse per 2, 4 or 8 PLL cycles; illegal codes stop the clock
  always_comb begin
    case (sel)
      CDC_DIV_HALF: nxt_en = (cnt[0] == 1'b1); // RULE5
      CDC_DIV_QUARTER: nxt_en = (cnt[1:0] == 2'h3);
      CDC_DIV_EIGHTH: nxt_en = (cnt == 3'h7);
      default: nxt_en = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      en <= 1'b0;
    end else begin
      en <= nxt_en;
    end
  end
endmodule

/* File: hdl/cdc_divider_ctrl.sv */
// clock divider ratio control: registers, prescaler and four derived clock enables
`timescale 1ns/1ps
// Operation
// RULE1: divide register 16-bit, word access only
// RULE2: pin power-on reset alone loads 0x36DB
// RULE3: software stops other modules before writing
// RULE4: bit 15 reads zero
// RULE5: core field selects half, quarter, eighth
// RULE6: bus field selects half, quarter, eighth
// RULE7: software never writes prohibited codes
// RULE8: core and bus fields reset to quarter
// RULE9: oscillator stop register 8-bit, byte access
// RULE10: peripheral and timer fields same encoding
// RULE11: bits 5 to 3 always read 011
// RULE12: divider input is PLL times eight
// RULE13: software keeps bus equal to peripheral
// RULE14: ratio change aligned to divider boundary
module cdc_divider_ctrl (
  // clock and resets
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic PIN_POWER_ON_N,
  // register port
  input wire logic [31:0] ADDR,
  input wire logic [1:0] ACC_SIZE,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic ACC_ERR,
  // oscillator monitor
  input wire logic OSC_STOPPED,
  output logic OSC_FLAG_OUT_SEL,
  // derived clock enables, one pulse per derived clock edge
  output cdc_pkg::cdc_clk_en_t CLK_EN
);
  import cdc_pkg::*;

  cdc_req_t req;
  logic [15:0] div_sel_ff;
  logic [15:0] pend_ff;
  logic [15:0] active_ff;
  logic [7:0] osc_ff;
  logic [2:0] cnt_ff;
  cdc_state_t state_ff;
  logic [15:0] rdata_ff;
  logic err_ff;
  logic hit_div;
  logic hit_osc;
  logic [15:0] wr_clean;
  cdc_clk_en_t en_w;

  assign req = '{addr: ADDR, size: ACC_SIZE, wdata: WDATA, wr: WR, rd: RD};
  assign hit_div = (req.addr == CDC_DIV_SEL_ADDR) && (req.size == CDC_SIZE_WORD); // RULE1
  assign hit_osc = (req.addr == CDC_OSC_STOP_ADDR) && (req.size == CDC_SIZE_BYTE); // RULE9

  // reserved bits forced so the stored word always reads back correctly
  always_comb begin
    wr_clean = req.wdata;
    wr_clean[CDC_RSVD_TOP_BIT] = 1'b0; // RULE4
    wr_clean[CDC_RSVD_LSB +: 3] = CDC_RSVD_VALUE; // RULE11
  end

  // only the pin power-on reset loads the divide word; other resets keep it
  always_ff @(posedge MCLK or negedge PIN_POWER_ON_N) begin
    if (!PIN_POWER_ON_N) begin
      div_sel_ff <= CDC_DIV_SEL_RESET; // RULE2 RULE8
    end else if (req.wr && hit_div) begin
      div_sel_ff <= wr_clean; // RULE1
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      osc_ff <= CDC_OSC_STOP_RESET; // RULE9
    end else begin
      if (req.wr && hit_osc) begin
        osc_ff[CDC_OSC_SELECT_BIT] <= req.wdata[CDC_OSC_SELECT_BIT];
      end
      if (OSC_STOPPED) begin
        osc_ff[CDC_OSC_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // prescaler running on the x8 PLL clock that MCLK stands for
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 3'h1; // RULE12
    end
  end

  // new ratios wait for the common boundary where every divider wraps
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= CDC_ST_LOAD;
      pend_ff <= CDC_DIV_SEL_RESET;
      active_ff <= CDC_DIV_SEL_RESET;
    end else begin
      case (state_ff)
        CDC_ST_RUN: begin
          if (div_sel_ff != active_ff) begin
            pend_ff <= div_sel_ff;
            state_ff <= CDC_ST_WAIT;
          end
        end
        CDC_ST_WAIT: begin
          if (cnt_ff == 3'h7) begin // RULE14
            state_ff <= CDC_ST_LOAD;
          end
        end
        CDC_ST_LOAD: begin
          active_ff <= (pend_ff == div_sel_ff) ? pend_ff : div_sel_ff; // RULE14
          state_ff <= CDC_ST_RUN;
        end
        default: state_ff <= CDC_ST_RUN;
      endcase
    end
  end

  cdc_clk_gate u_core (.MCLK(MCLK), .RESET_N(RESET_N), .cnt(cnt_ff),
    .sel(active_ff[CDC_CORE_LSB +: 3]), .en(en_w.core)); // RULE5
  cdc_clk_gate u_bus (.MCLK(MCLK), .RESET_N(RESET_N), .cnt(cnt_ff),
    .sel(active_ff[CDC_BUS_LSB +: 3]), .en(en_w.bus)); // RULE6
  cdc_clk_gate u_periph (.MCLK(MCLK), .RESET_N(RESET_N), .cnt(cnt_ff),
    .sel(active_ff[CDC_PERIPH_LSB +: 3]), .en(en_w.periph)); // RULE10
  cdc_clk_gate u_timer (.MCLK(MCLK), .RESET_N(RESET_N), .cnt(cnt_ff),
    .sel(active_ff[CDC_TIMER_LSB +: 3]), .en(en_w.timer)); // RULE10

  assign CLK_EN = en_w;

  // read data one cycle after the strobe; unmapped or wrong size reads zero and flags
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_ff <= '0;
      err_ff <= 1'b0;
    end else begin
      rdata_ff <= '0;
      err_ff <= (req.rd || req.wr) && !hit_div && !hit_osc;
      if (req.rd && hit_div) begin
        rdata_ff <= div_sel_ff; // RULE4 RULE11
      end else if (req.rd && hit_osc) begin
        rdata_ff <= {8'h00, osc_ff};
      end
    end
  end

  assign RDATA = rdata_ff;
  assign ACC_ERR = err_ff;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OSC_FLAG_OUT_SEL <= 1'b0;
    end else begin
      OSC_FLAG_OUT_SEL <= osc_ff[CDC_OSC_SELECT_BIT];
    end
  end

  // assertions
  sequence wr_div_s;
    req.wr && hit_div;
  endsequence

  word_write_a: assert property (@(posedge MCLK) disable iff (!PIN_POWER_ON_N)
    wr_div_s |=> div_sel_ff == $past(wr_clean)) else $error("word write lost"); // RULE1
  bit15_zero_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    req.rd && hit_div |=> rdata_ff[15] == 1'b0) else $error("bit 15 not zero"); // RULE4
  rsvd_field_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    req.rd && hit_div |=> rdata_ff[5:3] == 3'h3) else $error("reserved not 011"); // RULE11
  byte_only_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    req.wr && !hit_div && !hit_osc |=> err_ff) else $error("bad access unflagged"); // RULE9
  no_byte_div_a: assert property (@(posedge MCLK) disable iff (!PIN_POWER_ON_N)
    req.wr && req.addr == CDC_DIV_SEL_ADDR && req.size != CDC_SIZE_WORD
    |=> $stable(div_sel_ff)) else $error("non-word write took"); // RULE1
  quarter_core_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    active_ff[14:12] == 3'h3 && cnt_ff == 3'h3 |=> en_w.core) else $error("core quarter"); // RULE5
  half_bus_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    active_ff[11:9] == 3'h1 && cnt_ff[0] == 1'b0 |=> !en_w.bus) else $error("bus half"); // RULE6
  switch_bound_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    state_ff == CDC_ST_WAIT ##1 state_ff == CDC_ST_LOAD |-> $past(cnt_ff) == 3'h7)
    else $error("switch off boundary"); // RULE14
  switch_soon_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    state_ff == CDC_ST_WAIT |-> ##[1:9] state_ff == CDC_ST_RUN) else $error("switch stuck"); // RULE14
  pll_count_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    cnt_ff == 3'h7 |=> cnt_ff == 3'h0) else $error("prescaler wrap"); // RULE12

  sequence rd_osc_s;
    req.rd && hit_osc;
  endsequence

  sequence miss_rd_s;
    req.rd && !hit_div && !hit_osc;
  endsequence

  // reset split: the pin reset loads the word, the general reset leaves it alone
  div_reset_a: assert property (@(posedge MCLK) // RULE2 RULE8
    $rose(PIN_POWER_ON_N) |-> div_sel_ff == CDC_DIV_SEL_RESET)
    else $error("divide word not at reset value");
  kept_on_reset_a: assert property (@(posedge MCLK) disable iff (!PIN_POWER_ON_N) // RULE2
    !RESET_N && !(req.wr && hit_div) |=> $stable(div_sel_ff))
    else $error("general reset changed divide word");
  ratio_align_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE14
    active_ff != $past(active_ff) |-> cnt_ff == 3'h1)
    else $error("ratio changed off boundary");
  osc_read_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE9
    rd_osc_s |=> rdata_ff[15:3] == 13'h0 && !rdata_ff[1])
    else $error("osc reserved bits not zero");
  miss_read_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE1
    miss_rd_s |=> err_ff && rdata_ff == 16'h0000)
    else $error("bad read not refused");
  osc_set_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE9
    OSC_STOPPED |=> osc_ff[CDC_OSC_FLAG_BIT])
    else $error("stop flag not set");
  osc_sticky_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE9
    osc_ff[CDC_OSC_FLAG_BIT] |=> osc_ff[CDC_OSC_FLAG_BIT])
    else $error("stop flag lost");
  half_core_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE5
    active_ff[CDC_CORE_LSB +: 3] == CDC_DIV_HALF && cnt_ff[0] |=> en_w.core)
    else $error("core half");
  eighth_periph_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE10
    active_ff[CDC_PERIPH_LSB +: 3] == CDC_DIV_EIGHTH && cnt_ff != 3'h7 |=> !en_w.periph)
    else $error("periph eighth");
  eighth_timer_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE10
    active_ff[CDC_TIMER_LSB +: 3] == CDC_DIV_EIGHTH && cnt_ff == 3'h7 |=> en_w.timer)
    else $error("timer eighth");
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the clock divider ratio control
`timescale 1ns/1ps
module tb_top;
  import cdc_pkg::*;
  typedef struct {
    logic [31:0] a;
    logic [1:0] sz;
    logic [15:0] wd;
    logic [15:0] exp;
    logic err;
  } cdc_row_t;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic PIN_POWER_ON_N = 1'b0;
  logic [31:0] ADDR = 32'h0;
  logic [1:0] ACC_SIZE = 2'h0;
  logic [15:0] WDATA = 16'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic OSC_STOPPED = 1'b0;
  logic [15:0] RDATA;
  logic ACC_ERR;
  logic OSC_FLAG_OUT_SEL;
  cdc_clk_en_t CLK_EN;
  int n_fail = 0;
  int n_checks = 0;
  int cnt[4];
  logic [2:0] codes[3] = '{3'h1, 3'h3, 3'h4};
  cdc_row_t rows[6] = '{
    '{CDC_DIV_SEL_ADDR, CDC_SIZE_WORD, 16'h96C1, 16'h16D9, 1'b0},
    '{CDC_DIV_SEL_ADDR, CDC_SIZE_BYTE, 16'h1259, 16'h16D9, 1'b1},
    '{CDC_DIV_SEL_ADDR, CDC_SIZE_LONG, 16'h1259, 16'h16D9, 1'b1},
    '{CDC_OSC_STOP_ADDR, CDC_SIZE_BYTE, 16'h00FF, 16'h0001, 1'b0},
    '{CDC_OSC_STOP_ADDR, CDC_SIZE_WORD, 16'h0000, 16'h0001, 1'b1},
    '{CDC_DIV_SEL_ADDR, CDC_SIZE_WORD, 16'h36DB, 16'h36DB, 1'b0}};

  always #5 MCLK = ~MCLK;

  cdc_divider_ctrl dut (.MCLK(MCLK), .RESET_N(RESET_N), .PIN_POWER_ON_N(PIN_POWER_ON_N),
    .ADDR(ADDR), .ACC_SIZE(ACC_SIZE), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .ACC_ERR(ACC_ERR), .OSC_STOPPED(OSC_STOPPED), .OSC_FLAG_OUT_SEL(OSC_FLAG_OUT_SEL),
    .CLK_EN(CLK_EN));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one strobe cycle; returns just after the edge where RDATA and ACC_ERR settle
  task automatic acc(input logic [31:0] a, input logic [1:0] sz, input logic [15:0] wd,
                     input logic w);
    @(posedge MCLK);
    ADDR <= a;
    ACC_SIZE <= sz;
    WDATA <= wd;
    WR <= w;
    RD <= ~w;
    @(posedge MCLK);
    WR <= 1'b0;
    RD <= 1'b0;
    #1;
  endtask

  task automatic pulse_reset(input logic pin);
    @(posedge MCLK);
    if (pin) PIN_POWER_ON_N <= 1'b0;
    else RESET_N <= 1'b0;
    repeat (3) @(posedge MCLK);
    PIN_POWER_ON_N <= 1'b1;
    RESET_N <= 1'b1;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200us;
    n_fail++;
    $display("MISMATCH run time expected finish seen hang");
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge MCLK);
    RESET_N <= 1'b1;
    PIN_POWER_ON_N <= 1'b1;
    acc(CDC_DIV_SEL_ADDR, CDC_SIZE_WORD, 16'h0, 1'b0);
    chk("divide reset", RDATA, 16'h36DB);
    acc(CDC_OSC_STOP_ADDR, CDC_SIZE_BYTE, 16'h0, 1'b0);
    chk("osc reset", RDATA, 16'h0000);
    foreach (rows[i]) begin
      acc(rows[i].a, rows[i].sz, rows[i].wd, 1'b1);
      chk("write error", {15'h0, ACC_ERR}, {15'h0, rows[i].err});
      acc(rows[i].a, (rows[i].a == CDC_DIV_SEL_ADDR) ? CDC_SIZE_WORD : CDC_SIZE_BYTE,
          16'h0, 1'b0);
      chk("readback", RDATA, rows[i].exp);
    end
    chk("flag output select", {15'h0, OSC_FLAG_OUT_SEL}, 16'h0001);
    $display("register table test done");
    foreach (codes[k]) begin
      acc(CDC_DIV_SEL_ADDR, CDC_SIZE_WORD, {1'b0, codes[k], codes[k], codes[k], 3'h3, codes[k]},
          1'b1);
      repeat (16) @(posedge MCLK);
      cnt = '{0, 0, 0, 0};
      repeat (64) begin
        @(posedge MCLK);
        #1;
        cnt[0] += CLK_EN.core;
        cnt[1] += CLK_EN.bus;
        cnt[2] += CLK_EN.periph;
        cnt[3] += CLK_EN.timer;
      end
      for (int f = 0; f < 4; f++) begin
        chk("enable pulses", 16'(cnt[f]), 16'(64 >> (k + 1)));
      end
    end
    $display("divide ratio test done");
    acc(CDC_OSC_STOP_ADDR, CDC_SIZE_BYTE, 16'h0000, 1'b1);
    @(posedge MCLK);
    OSC_STOPPED <= 1'b1;
    #1;
    chk("flag output select", {15'h0, OSC_FLAG_OUT_SEL}, 16'h0000);
    acc(CDC_OSC_STOP_ADDR, CDC_SIZE_BYTE, 16'h0, 1'b0);
    chk("osc stop flag", RDATA, 16'h0004);
    @(posedge MCLK);
    OSC_STOPPED <= 1'b0;
    acc(32'hFFFFE802, CDC_SIZE_WORD, 16'h0, 1'b0);
    chk("unmapped error", {15'h0, ACC_ERR}, 16'h0001);
    chk("unmapped data", RDATA, 16'h0000);
    pulse_reset(1'b0);
    acc(CDC_DIV_SEL_ADDR, CDC_SIZE_WORD, 16'h0, 1'b0);
    chk("divide kept", RDATA, 16'h491C);
    acc(CDC_OSC_STOP_ADDR, CDC_SIZE_BYTE, 16'h0, 1'b0);
    chk("osc after reset", RDATA, 16'h0000);
    pulse_reset(1'b1);
    acc(CDC_DIV_SEL_ADDR, CDC_SIZE_WORD, 16'h0, 1'b0);
    chk("divide power on", RDATA, 16'h36DB);
    $display("reset test done");
    print_verdict();
  end
endmodule
